// ===== src/xlat_defines.svh
// address translator constants and rule summary
// Operation
// - take 32-bit kernel addresses, sort each into one of five segments
// - user segment from zero goes through the lookaside buffer
// - 0x80000000-0x9fffffff direct mapped, no buffer, cacheable
// - 0xa0000000-0xbfffffff direct mapped, no buffer, bypasses caches
// - both top segments from 0xc0000000 go through the lookaside buffer
// - cached direct segment: physical address is virtual with top 3 bits zero
// - buffer has 32 entries, each maps a virtual region onto two pages
// - each entry has own page size, 4k to 16M in steps of four
// - 8k write-back data cache, separate 16k instruction cache
`ifndef XLAT_DEFINES_SVH
`define XLAT_DEFINES_SVH
`define XL_SEG_USER         3'b0??
`define XL_SEG_CACHED       3'h4
`define XL_SEG_UNCACHED     3'h5
`define XL_SEG_LOWER_MAPPED 3'h6
`define XL_SEG_UPPER_MAPPED 3'h7
`define XL_DIRECT_MASK      32'h1fff_ffff
`define XL_TLB_ENTRIES      32
`define XL_PAGE_MIN_BYTES   32'h0000_1000
`define XL_PAGE_SIZE_MAX    3'h6
`define XL_PFN_W            20
`define XL_PAGE_OFS_ZERO    12'h000
`define XL_DCACHE_BYTES     32'h0000_2000
`define XL_ICACHE_BYTES     32'h0000_4000
`endif

// ===== src/xlat_pkg.sv
// types shared by the address translator modules
`include "xlat_defines.svh"
package xlat_pkg;
   typedef enum logic [2:0] {
      seg_user_mapped,
      seg_cached_direct,
      seg_uncached_direct,
      seg_lower_mapped,
      seg_upper_mapped
   } seg_e;

   typedef struct packed {
      logic [31:0]              vpair;
      logic [2:0]               size;
      logic [`XL_PFN_W-1:0]     pfn_even;
      logic [`XL_PFN_W-1:0]     pfn_odd;
      logic                     valid_even;
      logic                     valid_odd;
   } tlb_entry_s;

   typedef enum {
      st_idle,
      st_xlat,
      st_tag,
      st_wb,
      st_fill,
      st_uncached
   } xlat_state_e;
endpackage : xlat_pkg

// ===== src/tlb_port_if.sv
// lookup and write port between translator and lookaside buffer
`timescale 1ns/1ps
`include "xlat_defines.svh"
interface tlb_port_if;
   import xlat_pkg::*;
   localparam int IDX_W = $clog2(`XL_TLB_ENTRIES);
   logic                 wr_en;
   logic [IDX_W-1:0]     wr_index;
   tlb_entry_s           wr_entry;
   logic [31:0]          look_vaddr;
   logic                 look_hit;
   logic [31:0]          look_paddr;

   modport requester (
      output wr_en, wr_index, wr_entry, look_vaddr,
      input  look_hit, look_paddr
   );
   modport lookup (
      input  wr_en, wr_index, wr_entry, look_vaddr,
      output look_hit, look_paddr
   );
endinterface : tlb_port_if

// ===== src/tlb_lookup.sv
// fully associative lookaside buffer with per-entry page size
`timescale 1ns/1ps
`include "xlat_defines.svh"
module tlb_lookup #(
   parameter int ENTRIES = `XL_TLB_ENTRIES
) (
   // clock and reset
   input  wire logic     i_clk_sys,
   input  wire logic     i_reset,
   // translator side
   tlb_port_if.lookup    port
);
   import xlat_pkg::*;
   localparam int IDX_W = $clog2(ENTRIES);

   logic [ENTRIES-1:0]   valid_v;
   logic [31:0]          pa_v [ENTRIES];

   for (genvar g = 0; g < ENTRIES; g++)
   begin : g_entry
      tlb_entry_s        entry_nxt;
      tlb_entry_s        entry_r;
      logic [31:0]       ofs_mask;
      logic [31:0]       pair_mask;
      logic              odd;
      logic [31:0]       page_base;

      // load on write to this index; oversize codes clamp to 16M
      always_comb
      begin
         entry_nxt = entry_r;
         if (port.wr_en && port.wr_index == IDX_W'(g))
         begin
            entry_nxt = port.wr_entry;
            if (port.wr_entry.size > `XL_PAGE_SIZE_MAX)
               entry_nxt.size = `XL_PAGE_SIZE_MAX;
         end
      end

      // entry storage, all halves invalid after reset
      always_ff @(posedge i_clk_sys)
      begin
         if (i_reset)
            entry_r <= '0;
         else
            entry_r <= entry_nxt;
      end

      // page is 4k shifted by two bits per size step
      assign ofs_mask  = (`XL_PAGE_MIN_BYTES << {entry_r.size, 1'b0})
                         - 32'h0000_0001;
      assign pair_mask = {ofs_mask[30:0], 1'b1};
      assign odd       = |(port.look_vaddr & (ofs_mask + 32'h0000_0001));
      // one entry covers an even and an odd page
      assign valid_v[g] = (((port.look_vaddr ^ entry_r.vpair) & ~pair_mask)
                           == 32'h0000_0000)
                          && (odd ? entry_r.valid_odd
                                  : entry_r.valid_even);
      assign page_base = {odd ? entry_r.pfn_odd : entry_r.pfn_even,
                          `XL_PAGE_OFS_ZERO};
      assign pa_v[g]   = (page_base & ~ofs_mask)
                         | (port.look_vaddr & ofs_mask);
   end

   // lowest matching entry wins if software left duplicates
   always_comb
   begin
      port.look_hit   = 1'b0;
      port.look_paddr = 32'h0000_0000;
      for (int i = ENTRIES - 1; i >= 0; i--)
      begin
         if (valid_v[i])
         begin
            port.look_hit   = 1'b1;
            port.look_paddr = pa_v[i];
         end
      end
   end
endmodule : tlb_lookup

// ===== src/cpu_virtual_address_translator.sv
// virtual to physical translator with segment decode and caches
`timescale 1ns/1ps
`include "xlat_defines.svh"
module cpu_virtual_address_translator #(
   parameter int DCACHE_BYTES = `XL_DCACHE_BYTES,
   parameter int ICACHE_BYTES = `XL_ICACHE_BYTES
) (
   // clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_reset,
   // core request
   input  wire logic                 i_req_valid,
   output logic                      o_req_ready,
   input  wire logic [31:0]          i_req_vaddr,
   input  wire logic                 i_req_fetch,
   input  wire logic                 i_req_write,
   input  wire logic [31:0]          i_req_wdata,
   // core response
   output logic                      o_resp_valid,
   output logic [31:0]               o_resp_rdata,
   output logic                      o_resp_miss,
   output xlat_pkg::seg_e            o_resp_segment,
   // lookaside buffer load
   input  wire logic                 i_tlb_we,
   input  wire logic [4:0]           i_tlb_index,
   input  wire xlat_pkg::tlb_entry_s i_tlb_entry,
   // physical memory
   output logic                      o_mem_req,
   input  wire logic                 i_mem_ack,
   output logic                      o_mem_write,
   output logic [31:0]               o_mem_addr,
   output logic [31:0]               o_mem_wdata,
   input  wire logic [31:0]          i_mem_rdata
);
   import xlat_pkg::*;
   localparam int DC_WORDS = DCACHE_BYTES / 4;
   localparam int IC_WORDS = ICACHE_BYTES / 4;
   localparam int DC_IW    = $clog2(DC_WORDS);
   localparam int IC_IW    = $clog2(IC_WORDS);

   tlb_port_if tlb ();

   xlat_state_e          state_r, state_nxt;
   logic [31:0]          vaddr_r, vaddr_nxt;
   logic                 fetch_r, fetch_nxt;
   logic                 write_r, write_nxt;
   logic [31:0]          wdata_r, wdata_nxt;
   logic [31:0]          paddr_r, paddr_nxt;
   logic [31:0]          mem_addr_r, mem_addr_nxt;
   logic [31:0]          mem_wdata_r, mem_wdata_nxt;
   logic                 mem_write_r, mem_write_nxt;
   logic                 resp_valid_r, resp_valid_nxt;
   logic                 resp_miss_r, resp_miss_nxt;
   logic [31:0]          resp_rdata_r, resp_rdata_nxt;
   seg_e                 resp_seg_r, resp_seg_nxt;
   logic [DC_WORDS-1:0]  dc_valid_r, dc_valid_nxt;
   logic [IC_WORDS-1:0]  ic_valid_r, ic_valid_nxt;

   // cache arrays, one word per line, tag is the full word address
   logic [29:0]          dc_tag   [DC_WORDS];
   logic [31:0]          dc_data  [DC_WORDS];
   logic                 dc_dirty [DC_WORDS];
   logic [29:0]          ic_tag   [IC_WORDS];
   logic [31:0]          ic_data  [IC_WORDS];

   seg_e                 seg_w;
   logic                 mapped_w;
   logic [31:0]          xlat_pa;
   logic [DC_IW-1:0]     dc_idx;
   logic [IC_IW-1:0]     ic_idx;
   logic                 dc_hit;
   logic                 ic_hit;
   logic                 dc_we;
   logic                 dc_wdirty;
   logic [31:0]          dc_wdata;
   logic                 ic_we;

   // lookaside buffer hookup
   assign tlb.wr_en      = i_tlb_we;
   assign tlb.wr_index   = i_tlb_index;
   assign tlb.wr_entry   = i_tlb_entry;
   assign tlb.look_vaddr = vaddr_r;

   tlb_lookup #(
      .ENTRIES (`XL_TLB_ENTRIES)
   ) u_tlb (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .port      (tlb.lookup)
   );

   // segment decode on the top three address bits
   always_comb
   begin
      unique casez (vaddr_r[31:29])
         `XL_SEG_USER:         seg_w = seg_user_mapped;
         `XL_SEG_CACHED:       seg_w = seg_cached_direct;
         `XL_SEG_UNCACHED:     seg_w = seg_uncached_direct;
         `XL_SEG_LOWER_MAPPED: seg_w = seg_lower_mapped;
         `XL_SEG_UPPER_MAPPED: seg_w = seg_upper_mapped;
      endcase
   end

   // mapped segments use the buffer, direct ones drop the top bits
   assign mapped_w = (seg_w == seg_user_mapped)
                     || (seg_w == seg_lower_mapped)
                     || (seg_w == seg_upper_mapped);
   assign xlat_pa  = mapped_w ? tlb.look_paddr
                              : (vaddr_r & `XL_DIRECT_MASK);

   // cache lookup on the registered physical address
   assign dc_idx   = paddr_r[DC_IW+1:2];
   assign ic_idx   = paddr_r[IC_IW+1:2];
   assign dc_hit   = dc_valid_r[dc_idx] && (dc_tag[dc_idx] == paddr_r[31:2]);
   assign ic_hit   = ic_valid_r[ic_idx] && (ic_tag[ic_idx] == paddr_r[31:2]);
   assign dc_wdata = write_r ? wdata_r : i_mem_rdata;

   // handshakes and registered outputs
   assign o_req_ready    = (state_r == st_idle);
   assign o_mem_req      = (state_r == st_wb) || (state_r == st_fill)
                           || (state_r == st_uncached);
   assign o_mem_write    = mem_write_r;
   assign o_mem_addr     = mem_addr_r;
   assign o_mem_wdata    = mem_wdata_r;
   assign o_resp_valid   = resp_valid_r;
   assign o_resp_rdata   = resp_rdata_r;
   assign o_resp_miss    = resp_miss_r;
   assign o_resp_segment = resp_seg_r;

   // request sequencer next state
   always_comb
   begin
      state_nxt      = state_r;
      vaddr_nxt      = vaddr_r;
      fetch_nxt      = fetch_r;
      write_nxt      = write_r;
      wdata_nxt      = wdata_r;
      paddr_nxt      = paddr_r;
      mem_addr_nxt   = mem_addr_r;
      mem_wdata_nxt  = mem_wdata_r;
      mem_write_nxt  = mem_write_r;
      resp_valid_nxt = 1'b0;
      resp_miss_nxt  = 1'b0;
      resp_rdata_nxt = resp_rdata_r;
      resp_seg_nxt   = resp_seg_r;
      dc_we          = 1'b0;
      dc_wdirty      = 1'b0;
      ic_we          = 1'b0;
      unique case (state_r)
         st_idle:
         begin
            if (i_req_valid)
            begin
               vaddr_nxt = i_req_vaddr;
               fetch_nxt = i_req_fetch;
               write_nxt = i_req_write && !i_req_fetch;
               wdata_nxt = i_req_wdata;
               state_nxt = st_xlat;
            end
         end
         st_xlat:
         begin
            resp_seg_nxt = seg_w;
            paddr_nxt    = xlat_pa;
            if (mapped_w && !tlb.look_hit)
            begin
               resp_valid_nxt = 1'b1;
               resp_miss_nxt  = 1'b1;
               resp_rdata_nxt = 32'h0000_0000;
               state_nxt      = st_idle;
            end
            else if (seg_w == seg_uncached_direct)
            begin
               mem_addr_nxt  = xlat_pa;
               mem_write_nxt = write_r;
               mem_wdata_nxt = wdata_r;
               state_nxt     = st_uncached;
            end
            else
               state_nxt = st_tag;
         end
         st_tag:
         begin
            if (fetch_r && ic_hit)
            begin
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = ic_data[ic_idx];
               state_nxt      = st_idle;
            end
            else if (!fetch_r && dc_hit)
            begin
               dc_we          = write_r;
               dc_wdirty      = 1'b1;
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = write_r ? 32'h0000_0000 : dc_data[dc_idx];
               state_nxt      = st_idle;
            end
            else if (!fetch_r && dc_valid_r[dc_idx] && dc_dirty[dc_idx])
            begin
               mem_addr_nxt  = {dc_tag[dc_idx], 2'b00};
               mem_wdata_nxt = dc_data[dc_idx];
               mem_write_nxt = 1'b1;
               state_nxt     = st_wb;
            end
            else if (write_r)
            begin
               dc_we          = 1'b1;
               dc_wdirty      = 1'b1;
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = 32'h0000_0000;
               state_nxt      = st_idle;
            end
            else
            begin
               mem_addr_nxt  = paddr_r;
               mem_write_nxt = 1'b0;
               state_nxt     = st_fill;
            end
         end
         st_wb:
         begin
            if (i_mem_ack && write_r)
            begin
               dc_we          = 1'b1;
               dc_wdirty      = 1'b1;
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = 32'h0000_0000;
               state_nxt      = st_idle;
            end
            else if (i_mem_ack)
            begin
               mem_addr_nxt  = paddr_r;
               mem_write_nxt = 1'b0;
               state_nxt     = st_fill;
            end
         end
         st_fill:
         begin
            if (i_mem_ack)
            begin
               ic_we          = fetch_r;
               dc_we          = !fetch_r;
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = i_mem_rdata;
               state_nxt      = st_idle;
            end
         end
         st_uncached:
         begin
            if (i_mem_ack)
            begin
               resp_valid_nxt = 1'b1;
               resp_rdata_nxt = write_r ? 32'h0000_0000 : i_mem_rdata;
               state_nxt      = st_idle;
            end
         end
      endcase
      dc_valid_nxt = dc_valid_r;
      ic_valid_nxt = ic_valid_r;
      if (dc_we)
         dc_valid_nxt[dc_idx] = 1'b1;
      if (ic_we)
         ic_valid_nxt[ic_idx] = 1'b1;
   end

   // sequencer registers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset)
      begin
         state_r      <= st_idle;
         vaddr_r      <= 32'h0000_0000;
         fetch_r      <= 1'b0;
         write_r      <= 1'b0;
         wdata_r      <= 32'h0000_0000;
         paddr_r      <= 32'h0000_0000;
         mem_addr_r   <= 32'h0000_0000;
         mem_wdata_r  <= 32'h0000_0000;
         mem_write_r  <= 1'b0;
         resp_valid_r <= 1'b0;
         resp_miss_r  <= 1'b0;
         resp_rdata_r <= 32'h0000_0000;
         resp_seg_r   <= seg_user_mapped;
         dc_valid_r   <= '0;
         ic_valid_r   <= '0;
      end
      else
      begin
         state_r      <= state_nxt;
         vaddr_r      <= vaddr_nxt;
         fetch_r      <= fetch_nxt;
         write_r      <= write_nxt;
         wdata_r      <= wdata_nxt;
         paddr_r      <= paddr_nxt;
         mem_addr_r   <= mem_addr_nxt;
         mem_wdata_r  <= mem_wdata_nxt;
         mem_write_r  <= mem_write_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_miss_r  <= resp_miss_nxt;
         resp_rdata_r <= resp_rdata_nxt;
         resp_seg_r   <= resp_seg_nxt;
         dc_valid_r   <= dc_valid_nxt;
         ic_valid_r   <= ic_valid_nxt;
      end
   end

   // cache array writes; valid bits above guard stale contents
   always_ff @(posedge i_clk_sys)
   begin
      if (dc_we)
      begin
         dc_tag[dc_idx]   <= paddr_r[31:2];
         dc_data[dc_idx]  <= dc_wdata;
         dc_dirty[dc_idx] <= dc_wdirty;
      end
      if (ic_we)
      begin
         ic_tag[ic_idx]  <= paddr_r[31:2];
         ic_data[ic_idx] <= i_mem_rdata;
      end
   end
endmodule : cpu_virtual_address_translator

// ===== tb/xlat_props.sv
// checker for the translator's core and memory port behaviour
`timescale 1ns/1ps
`include "xlat_defines.svh"
module xlat_props
(
   // clock and reset
   input  wire logic           i_clk_sys,
   input  wire logic           i_reset,
   // core side
   input  wire logic           i_req_valid,
   input  wire logic           o_req_ready,
   input  wire logic [31:0]    i_req_vaddr,
   input  wire logic           o_resp_valid,
   input  wire logic           o_resp_miss,
   input  wire xlat_pkg::seg_e o_resp_segment,
   // memory side
   input  wire logic           o_mem_req,
   input  wire logic           i_mem_ack,
   input  wire logic           o_mem_write,
   input  wire logic [31:0]    o_mem_addr
);
   import xlat_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   logic        take;
   logic [31:0] va_r;
   // a request is taken on a ready edge
   assign take = i_req_valid && o_req_ready;
   // address of the request in flight
   always_ff @(posedge i_clk_sys)
   begin
      if (i_reset) va_r <= 32'h0000_0000;
      else if (take) va_r <= i_req_vaddr;
   end
   // segment expected from the top three address bits
   function automatic seg_e seg_of(logic [2:0] t);
      case (t)
         3'h4:    return seg_cached_direct;
         3'h5:    return seg_uncached_direct;
         3'h6:    return seg_lower_mapped;
         3'h7:    return seg_upper_mapped;
         default: return seg_user_mapped;
      endcase
   endfunction : seg_of
   sequence s_take;
      take;
   endsequence
   sequence s_mem_wait;
      o_mem_req && !i_mem_ack;
   endsequence
   a_ready_busy: assert property (s_take |=> !o_req_ready)
      else $error("ready high while a request is busy");
   a_resp_ready: assert property (o_resp_valid |-> o_req_ready)
      else $error("not ready in response cycle");
   a_resp_pulse: assert property (o_resp_valid |=> !o_resp_valid)
      else $error("response valid longer than one cycle");
   a_miss_two: assert property (o_resp_miss |-> o_resp_valid && $past(take, 2))
      else $error("miss not two cycles after take");
   a_direct_no_miss: assert property
      (o_resp_valid && va_r[31:30] == 2'b10 |-> !o_resp_miss)
      else $error("miss raised in direct segment");
   a_seg_match: assert property
      (o_resp_valid |-> o_resp_segment == seg_of(va_r[31:29]))
      else $error("segment does not match address");
   a_uncached_addr: assert property
      (o_mem_req && va_r[31:29] == 3'h5
       |-> o_mem_addr == (va_r & `XL_DIRECT_MASK))
      else $error("uncached memory address wrong");
   a_cached_fill: assert property
      (o_mem_req && !o_mem_write && va_r[31:29] == 3'h4
       |-> o_mem_addr[31:2] == {3'b000, va_r[28:2]})
      else $error("cached fill address wrong");
   a_mem_hold: assert property (s_mem_wait |=> o_mem_req
      && $stable(o_mem_addr) && $stable(o_mem_write))
      else $error("memory request changed before ack");
endmodule : xlat_props
bind cpu_virtual_address_translator xlat_props u_xlat_props (
   .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid),
   .o_req_ready(o_req_ready), .i_req_vaddr(i_req_vaddr),
   .o_resp_valid(o_resp_valid), .o_resp_miss(o_resp_miss),
   .o_resp_segment(o_resp_segment), .o_mem_req(o_mem_req),
   .i_mem_ack(i_mem_ack), .o_mem_write(o_mem_write),
   .o_mem_addr(o_mem_addr));

// ===== tb/core_model.sv
// processor core model issuing one request at a time
`timescale 1ns/1ps
module core_model
(
   // clock
   input  wire logic           i_clk_sys,
   // request
   output logic                o_valid,
   input  wire logic           i_ready,
   output logic [31:0]         o_vaddr,
   output logic                o_fetch,
   output logic                o_write,
   output logic [31:0]         o_wdata,
   // response
   input  wire logic           i_resp_valid,
   input  wire logic [31:0]    i_resp_rdata,
   input  wire logic           i_resp_miss,
   input  wire xlat_pkg::seg_e i_resp_seg
);
   import xlat_pkg::*;
   // idle request lines at time zero
   initial
   begin
      o_valid = 1'b0;
      o_vaddr = 32'h0000_0000;
      o_fetch = 1'b0;
      o_write = 1'b0;
      o_wdata = 32'h0000_0000;
   end
   // hold the request until a ready edge, then wait for the answer
   task automatic issue(input logic [31:0] va, input logic f, w,
      input logic [31:0] wd, output logic [31:0] rd, output logic ms,
      output seg_e sg, output logic ok);
      int n;
      @(negedge i_clk_sys);
      o_valid = 1'b1;
      o_vaddr = va;
      o_fetch = f;
      o_write = w;
      o_wdata = wd;
      for (n = 0; n < 50 && i_ready !== 1'b1; n++) @(negedge i_clk_sys);
      ok = (i_ready === 1'b1);
      @(negedge i_clk_sys);
      o_valid = 1'b0;
      o_vaddr = ~va;
      o_wdata = ~wd;
      for (n = 0; n < 200 && i_resp_valid !== 1'b1; n++)
         @(negedge i_clk_sys);
      ok = ok && (i_resp_valid === 1'b1);
      rd = i_resp_rdata;
      ms = i_resp_miss;
      sg = i_resp_seg;
   endtask : issue
endmodule : core_model

// ===== tb/tb_cpu_virtual_address_translator.sv
// testbench for the virtual address translator
`timescale 1ns/1ps
module tb_cpu_virtual_address_translator;
   import xlat_pkg::*;
   logic        i_clk_sys, i_reset, req_valid, req_ready, req_fetch;
   logic        req_write, resp_valid, resp_miss, tlb_we, mem_req;
   logic        mem_ack, mem_write, ms;
   logic [31:0] req_vaddr, req_wdata, resp_rdata, mem_addr, mem_wdata;
   logic [31:0] mem_rdata, rd;
   logic [4:0]  tlb_index;
   tlb_entry_s  tlb_entry;
   seg_e        resp_seg, sg;
   int          mismatches, n_compared, mem_delay, wcnt;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] log_a [$];
   logic [31:0] log_d [$];
   logic        log_w [$];
   cpu_virtual_address_translator #(.DCACHE_BYTES(64), .ICACHE_BYTES(64))
   u_cpu_virtual_address_translator (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req_vaddr(req_vaddr),
      .i_req_fetch(req_fetch), .i_req_write(req_write),
      .i_req_wdata(req_wdata), .o_resp_valid(resp_valid),
      .o_resp_rdata(resp_rdata), .o_resp_miss(resp_miss),
      .o_resp_segment(resp_seg), .i_tlb_we(tlb_we),
      .i_tlb_index(tlb_index), .i_tlb_entry(tlb_entry),
      .o_mem_req(mem_req), .i_mem_ack(mem_ack), .o_mem_write(mem_write),
      .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
      .i_mem_rdata(mem_rdata));
   core_model u_core_model (
      .i_clk_sys(i_clk_sys), .o_valid(req_valid), .i_ready(req_ready),
      .o_vaddr(req_vaddr), .o_fetch(req_fetch), .o_write(req_write),
      .o_wdata(req_wdata), .i_resp_valid(resp_valid),
      .i_resp_rdata(resp_rdata), .i_resp_miss(resp_miss),
      .i_resp_seg(resp_seg));
   // clock at 250 MHz
   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   // memory word, with a fixed pattern where never written
   function automatic logic [31:0] word(logic [31:0] a);
      return mem.exists(a) ? mem[a] : a ^ 32'h5a5a_a5a5;
   endfunction : word
   // physical memory: acks after mem_delay cycles and logs each access
   always @(negedge i_clk_sys)
   begin
      if (mem_ack)
      begin
         mem_ack = 1'b0;
         mem_rdata = ~mem_rdata;
         wcnt = 0;
      end
      else if (mem_req === 1'b1)
      begin
         if (wcnt < mem_delay) wcnt++;
         else
         begin
            mem_ack = 1'b1;
            log_a.push_back(mem_addr);
            log_w.push_back(mem_write);
            log_d.push_back(mem_wdata);
            if (mem_write) mem[mem_addr] = mem_wdata;
            else mem_rdata = word(mem_addr);
         end
      end
   end
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // one request with a cleared memory log
   task automatic rq(logic [31:0] va, logic f, w, logic [31:0] wd);
      logic ok;
      log_a.delete();
      log_w.delete();
      log_d.delete();
      u_core_model.issue(va, f, w, wd, rd, ms, sg, ok);
      if (!ok)
      begin
         mismatches++;
         wrap_up();
      end
   endtask : rq
   task automatic ld(logic [4:0] ix, logic [31:0] vp, logic [2:0] sz,
      logic [19:0] pe, po);
      @(negedge i_clk_sys);
      tlb_we = 1'b1;
      tlb_index = ix;
      tlb_entry = '{vp, sz, pe, po, 1'b1, 1'b1};
      @(negedge i_clk_sys);
      tlb_we = 1'b0;
   endtask : ld
   task automatic t_reset;
      chk("ready", 32'(req_ready), 32'h0000_0001);
      chk("segment", 32'(resp_seg), 32'h0000_0000);
      chk("mem_req", 32'(mem_req), 32'h0000_0000);
   endtask : t_reset
   task automatic t_segments;
      logic [31:0] va [10] = '{32'h0000_1000, 32'h7fff_fffc, 32'hc000_0000,
         32'hdfff_fffc, 32'he000_0000, 32'hffff_fffc, 32'h8000_0000,
         32'h9fff_fffc, 32'ha000_0000, 32'hbfff_fffc};
      seg_e es [10] = '{seg_user_mapped, seg_user_mapped, seg_lower_mapped,
         seg_lower_mapped, seg_upper_mapped, seg_upper_mapped,
         seg_cached_direct, seg_cached_direct, seg_uncached_direct,
         seg_uncached_direct};
      for (int i = 0; i < 10; i++)
      begin
         rq(va[i], 1'b0, 1'b0, 32'h0000_0000);
         chk("segment", 32'(sg), 32'(es[i]));
         chk("miss", 32'(ms), 32'(i < 6));
      end
   endtask : t_segments
   task automatic t_uncached;
      mem_delay = 0;
      rq(32'ha000_0040, 1'b0, 1'b0, 32'h0000_0000);
      chk("unc addr", log_a[0], 32'h0000_0040);
      chk("unc data", rd, word(32'h0000_0040));
      mem_delay = 3;
      rq(32'ha000_0044, 1'b0, 1'b1, 32'h1234_5678);
      chk("unc wr", 32'(log_w[0]), 32'h0000_0001);
      chk("unc wdata", log_d[0], 32'h1234_5678);
      rq(32'ha000_0044, 1'b0, 1'b0, 32'h0000_0000);
      chk("unc back", rd, 32'h1234_5678);
      chk("unc count", 32'(log_a.size()), 32'h0000_0001);
   endtask : t_uncached
   task automatic t_cached;
      mem_delay = 1;
      rq(32'h8000_0010, 1'b0, 1'b1, 32'hcafe_0001);
      chk("wr count", 32'(log_a.size()), 32'h0000_0000);
      rq(32'h8000_0010, 1'b0, 1'b0, 32'h0000_0000);
      chk("hit data", rd, 32'hcafe_0001);
      chk("hit count", 32'(log_a.size()), 32'h0000_0000);
      rq(32'h8000_0050, 1'b0, 1'b0, 32'h0000_0000);
      chk("wb addr", log_a[0], 32'h0000_0010);
      chk("wb data", log_d[0], 32'hcafe_0001);
      chk("fill addr", log_a[1], 32'h0000_0050);
      chk("fill data", rd, word(32'h0000_0050));
   endtask : t_cached
   task automatic t_fetch;
      rq(32'h8000_0060, 1'b1, 1'b0, 32'h0000_0000);
      chk("if fill", log_a[0], 32'h0000_0060);
      rq(32'h8000_0060, 1'b1, 1'b0, 32'h0000_0000);
      chk("if hit", 32'(log_a.size()), 32'h0000_0000);
      chk("if data", rd, word(32'h0000_0060));
      rq(32'h8000_0060, 1'b0, 1'b0, 32'h0000_0000);
      chk("d split", 32'(log_a.size()), 32'h0000_0001);
   endtask : t_fetch
   task automatic t_tlb;
      ld(5'd31, 32'h0000_0000, 3'h0, 20'h0_0123, 20'h0_0456);
      rq(32'h0000_1008, 1'b0, 1'b0, 32'h0000_0000);
      chk("odd page", log_a[0], 32'h0045_6008);
      rq(32'h0000_0008, 1'b0, 1'b0, 32'h0000_0000);
      chk("even page", log_a[0], 32'h0012_3008);
      ld(5'd5, 32'hc000_0000, 3'h1, 20'h0_0a00, 20'h0_0800);
      rq(32'hc000_4010, 1'b0, 1'b0, 32'h0000_0000);
      chk("16k odd", log_a[0], 32'h0080_0010);
      rq(32'hc000_1010, 1'b0, 1'b0, 32'h0000_0000);
      chk("16k even", log_a[0], 32'h00a0_1010);
      chk("16k miss", 32'(ms), 32'h0000_0000);
      ld(5'd6, 32'he000_0000, 3'h7, 20'h0_1000, 20'h0_2000);
      rq(32'he100_0020, 1'b0, 1'b0, 32'h0000_0000);
      chk("16m clamp", log_a[0], 32'h0200_0020);
   endtask : t_tlb
   // main sequence
   initial
   begin
      mismatches = 0;
      n_compared = 0;
      mem_delay = 0;
      wcnt = 0;
      i_reset = 1'b1;
      tlb_we = 1'b0;
      tlb_index = 5'h00;
      tlb_entry = '0;
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      repeat (8) @(negedge i_clk_sys);
      i_reset = 1'b0;
      t_reset();
      t_segments();
      t_uncached();
      t_cached();
      t_fetch();
      t_tlb();
      wrap_up();
   end
endmodule : tb_cpu_virtual_address_translator
